// ===== core/speed_torque_command_select.sv
`timescale 1ns/1ps
// command selection for speed and torque modes with digital speed capture
`include "stcs_defs.svh"
module speed_torque_command_select import stcs_pkg::*; #(
  parameter int W = 16,
  parameter int STROBE_CYCLES = `STROBE_CYC,
  parameter int STABLE_CYCLES = `STABLE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // configuration
  input wire logic torque_mode,
  input wire logic bcd_mode,
  input wire logic auto_read,
  input wire logic sel3_enable,
  input wire logic [W-1:0] full_scale_speed,
  input wire logic [W-1:0] max_speed,
  input wire logic [W-1:0] torque_gain,
  input wire logic signed [15:0] torque_offset_mv,
  // internal speed table load, address 1..7
  input wire logic tbl_wr,
  input wire logic [2:0] tbl_addr,
  input wire logic [W-1:0] tbl_data,
  // contact inputs, high when closed to common
  input wire logic [19:0] data_in,
  input wire logic source_select_in,
  input wire logic speed_sel1_in,
  input wire logic speed_sel2_in,
  input wire logic speed_sel3_in,
  input wire logic reverse_select_in,
  input wire logic forward_select_in,
  input wire logic data_strobe_in,
  // analog values, already digitised
  input wire logic signed [W-1:0] analog_speed_cmd,
  input wire logic signed [W-1:0] analog_speed_limit,
  input wire logic signed [15:0] analog_torque_cmd,
  input wire logic [W-1:0] motor_speed,
  // results
  output logic [W-1:0] speed_cmd,
  output logic signed [W-1:0] torque_cmd,
  output dir_t torque_dir,
  output dir_t limit_dir,
  output logic speed_reached_out,
  output logic speed_limiting_out
);
  // pin synchronisers
  logic [26:0] s1_ff, s2_ff;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else if (clk_en) begin
      s1_ff <= {data_strobe_in, forward_select_in, reverse_select_in,
                speed_sel3_in, speed_sel2_in, speed_sel1_in,
                source_select_in, data_in};
      s2_ff <= s1_ff;
    end
  end
  wire [19:0] din = s2_ff[19:0];
  wire src_sel = s2_ff[20];
  wire [2:0] sel = {s2_ff[23] & sel3_enable, s2_ff[22], s2_ff[21]};
  wire rev = s2_ff[24];
  wire fwd = s2_ff[25];
  wire stb = s2_ff[26];

  function automatic logic [W-1:0] bcd_to_bin(input logic [19:0] b);
    logic [31:0] v;
    v = 32'(b[19:16]) * 32'd10000 + 32'(b[15:12]) * 32'd1000 +
        32'(b[11:8]) * 32'd100 + 32'(b[7:4]) * 32'd10 + 32'(b[3:0]);
    return (v > 32'(max_speed)) ? max_speed : v[W-1:0];
  endfunction

  function automatic logic [W-1:0] abs_w(input logic signed [W-1:0] x);
    return x[W-1] ? W'(-x) : W'(x);
  endfunction

  // capture of the digital word
  logic [19:0] word_ff, nxt_word;
  logic [19:0] last_ff, nxt_last;
  logic [31:0] cnt_ff, nxt_cnt;
  logic done_ff, nxt_done;
  always_comb begin
    nxt_word = word_ff;
    nxt_last = din;
    nxt_cnt = cnt_ff;
    nxt_done = done_ff;
    if (auto_read) begin
      // stability timer restarts on any change; strobe ignored
      if (din != last_ff) begin
        nxt_cnt = '0;
      end else if (cnt_ff < 32'(STABLE_CYCLES)) begin
        nxt_cnt = cnt_ff + 32'd1;
      end else begin
        nxt_word = din;
      end
      nxt_done = 1'b0;
    end else if (!stb || din != last_ff) begin
      // data must hold steady for STROBE_CYCLES cycles of the strobe
      nxt_cnt = '0;
      nxt_done = 1'b0;
    end else if (!done_ff) begin
      if (cnt_ff + 32'd1 >= 32'(STROBE_CYCLES)) begin
        nxt_word = din;
        nxt_done = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 32'd1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      word_ff <= '0;
      last_ff <= '0;
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else if (clk_en) begin
      word_ff <= nxt_word;
      last_ff <= nxt_last;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  // internal speeds; torque mode uses only entries 1..3
  logic [W-1:0] tbl_q;
  wire [2:0] rd_sel = torque_mode ? {1'b0, sel[1:0]} : sel;
  speed_table #(.W(W)) u_tbl (
    .clk(clk),
    .ce(clk_en),
    .wr_en(tbl_wr),
    .wr_addr(tbl_addr),
    .wr_data(tbl_data),
    .rd_addr(rd_sel),
    .rd_data(tbl_q)
  );

  // binary word scaled linearly, all ones gives full scale
  wire [31:0] bin_prod = 32'(word_ff[11:0]) * 32'(full_scale_speed);
  wire [W-1:0] bin_speed = W'(bin_prod / 32'(`BIN_FULL));

  logic [W-1:0] speed_ff, nxt_speed, lim_ff, nxt_lim;
  logic signed [W-1:0] trq_ff, nxt_trq;
  dir_t tdir_ff, nxt_tdir, ldir_ff, nxt_ldir;
  logic reach_ff, nxt_reach, limiting_ff, nxt_limiting;
  logic signed [31:0] t_mv;
  logic [W-1:0] delta;
  // analog limit sign kept for direction choice
  wire ana_lim_sel = (sel[1:0] == 2'b00);
  always_comb begin
    // speed command source
    if (bcd_mode) begin
      nxt_speed = bcd_to_bin(word_ff);
    end else if (!src_sel) begin
      nxt_speed = bin_speed;
    end else if (sel == 3'b000) begin
      nxt_speed = abs_w(analog_speed_cmd);
    end else begin
      nxt_speed = tbl_q;
    end
    // speed limit in torque mode
    nxt_lim = ana_lim_sel ? abs_w(analog_speed_limit) : tbl_q;
    // torque: offset then gain, gain reached at full-scale volts
    t_mv = 32'(analog_torque_cmd) + 32'(torque_offset_mv);
    nxt_trq = W'((t_mv * $signed(32'(torque_gain))) /
                 32'(`FULL_TORQUE_MV));
    case ({rev, fwd})
      2'b10: nxt_tdir = t_mv > 0 ? DIR_CW : (t_mv < 0 ? DIR_CCW : DIR_NONE);
      2'b01: nxt_tdir = t_mv > 0 ? DIR_CCW : (t_mv < 0 ? DIR_CW : DIR_NONE);
      default: nxt_tdir = DIR_NONE;
    endcase
    case ({rev, fwd})
      2'b01: nxt_ldir = (ana_lim_sel && analog_speed_limit < 0) ?
                        DIR_CW : DIR_CCW;
      2'b10: nxt_ldir = (ana_lim_sel && analog_speed_limit < 0) ?
                        DIR_CCW : DIR_CW;
      default: nxt_ldir = DIR_NONE;
    endcase
    if (!torque_mode) begin
      nxt_trq = '0;
      nxt_tdir = DIR_NONE;
      nxt_ldir = DIR_NONE;
    end
    // speed reached: within a small window of the command
    delta = (motor_speed > speed_ff) ? motor_speed - speed_ff :
            speed_ff - motor_speed;
    nxt_reach = !torque_mode && (delta <= W'(`NEAR_WINDOW));
    nxt_limiting = torque_mode && (motor_speed >= lim_ff);
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      speed_ff <= '0;
      lim_ff <= '0;
      trq_ff <= '0;
      tdir_ff <= DIR_NONE;
      ldir_ff <= DIR_NONE;
      reach_ff <= 1'b0;
      limiting_ff <= 1'b0;
    end else if (clk_en) begin
      speed_ff <= nxt_speed;
      lim_ff <= nxt_lim;
      trq_ff <= nxt_trq;
      tdir_ff <= nxt_tdir;
      ldir_ff <= nxt_ldir;
      reach_ff <= nxt_reach;
      limiting_ff <= nxt_limiting;
    end
  end
  assign speed_cmd = speed_ff;
  assign torque_cmd = trq_ff;
  assign torque_dir = tdir_ff;
  assign limit_dir = ldir_ff;
  assign speed_reached_out = reach_ff;
  assign speed_limiting_out = limiting_ff;
endmodule

// ===== inc/stcs_defs.svh
// constants for the speed and torque command selection block
// How it works
// - speed mode: speed-reached output when motor speed near selected command
// - binary mode builds a 12-bit speed word from data bits 0..11
// - all ones in the binary word commands the full-scale speed parameter
// - source select off: digital word is the command, selection inputs ignored
// - source select on: 3-bit code picks analog or internal speeds 1-7
// - BCD mode decodes five digits from bits 0..19, clamped to max speed
// - BCD mode ignores source select and selection inputs
// - closed contact reads as one, open contact as zero
// - auto-read ignores strobe, adopts data stable over 12 ms
// - torque direction from forward/reverse selects and command sign
// - full torque at 8 V command, scalable by torque gain parameter
// - signed millivolt offset within +-9999 added to torque command
// - speed limit direction from selects and analog limit sign
// - torque mode: 2-bit code picks analog limit or internal limits 1-3
// - torque mode: limiting output when speed reaches active limit
`ifndef STCS_DEFS_SVH
`define STCS_DEFS_SVH
`define CLK_HZ 25000000
`define STROBE_MIN_MS 10
`define STABLE_MIN_MS 12
`define STROBE_CYC ((`STROBE_MIN_MS * `CLK_HZ) / 1000 + 1)
`define STABLE_CYC ((`STABLE_MIN_MS * `CLK_HZ) / 1000 + 1)
`define BIN_FULL 12'hFFF
`define FULL_TORQUE_MV 8000
`define OFS_MAX_MV 9999
`define NEAR_WINDOW 16'h000A
`endif

// ===== inc/stcs_pkg.sv
// types for the speed and torque command selection block
package stcs_pkg;
  typedef enum logic [1:0] {DIR_NONE, DIR_CW, DIR_CCW} dir_t;
  typedef enum logic {MODE_SPEED, MODE_TORQUE} ctrl_mode_t;
endpackage

// ===== core/speed_table.sv
`timescale 1ns/1ps
// small register memory of internal speed values with registered read
module speed_table #(
  parameter int W = 16
) (
  // clock
  input wire logic clk,
  input wire logic ce,
  // write
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  // read
  input wire logic [2:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [0:7];
  logic [W-1:0] rd_ff;
  assign rd_data = rd_ff;
  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_ff <= mem[rd_addr];
    end
  end
endmodule

// ===== sim/stcs_sva.sv
// checker for the command selection block
`timescale 1ns/1ps
module stcs_sva import stcs_pkg::*; #(
  parameter int W = 16,
  parameter int STROBE_CYCLES = 20,
  parameter int STABLE_CYCLES = 20
) (
  // clock, reset and inputs
  input wire logic clk, sys_rst, torque_mode, bcd_mode, auto_read,
  input wire logic source_select_in, speed_sel1_in, speed_sel2_in,
  input wire logic reverse_select_in, forward_select_in, data_strobe_in,
  input wire logic [19:0] data_in,
  input wire logic signed [W-1:0] analog_speed_limit,
  input wire logic signed [15:0] analog_torque_cmd,
  input wire logic [W-1:0] motor_speed,
  // outputs
  input wire logic [W-1:0] speed_cmd,
  input wire logic signed [W-1:0] torque_cmd,
  input wire dir_t torque_dir, limit_dir,
  input wire logic speed_limiting_out
);
  int hi_ff;
  int st_ff;
  logic stb_ff;
  // strobe length is held after the fall, the capture lands later
  always_ff @(posedge clk) begin
    stb_ff <= data_strobe_in;
    hi_ff <= !data_strobe_in ? hi_ff : stb_ff ? hi_ff + 1 : 1;
    st_ff <= $changed(data_in) ? 0 : st_ff + 1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_strobe_min: assert property (
    (!auto_read && !bcd_mode && !torque_mode && !source_select_in)[*8]
    ##0 $changed(speed_cmd) |-> hi_ff >= STROBE_CYCLES)
    else $error("word taken on short strobe");
  a_auto_stable: assert property (
    (auto_read && !bcd_mode && !torque_mode && !source_select_in)[*8]
    ##0 $changed(speed_cmd) |-> st_ff >= STABLE_CYCLES)
    else $error("word taken before data settled");
  a_dir_none: assert property (
    (torque_mode && forward_select_in == reverse_select_in)[*6]
    |=> torque_dir == DIR_NONE) else $error("torque with equal selects");
  a_dir_rev: assert property (
    (torque_mode && reverse_select_in && !forward_select_in
    && analog_torque_cmd > 0)[*6] |=> torque_dir == DIR_CW)
    else $error("reverse direction wrong");
  a_dir_fwd: assert property (
    (torque_mode && forward_select_in && !reverse_select_in
    && analog_torque_cmd > 0)[*6] |=> torque_dir == DIR_CCW)
    else $error("forward direction wrong");
  a_limit_dir: assert property (
    (torque_mode && forward_select_in && !reverse_select_in
    && analog_speed_limit > 0)[*6] |=> limit_dir == DIR_CCW)
    else $error("limit direction wrong");
  a_torque_off: assert property (
    !torque_mode [*6] |=> torque_cmd == 0) else $error("torque in speed mode");
  a_limit_hit: assert property (
    (torque_mode && !speed_sel1_in && !speed_sel2_in && analog_speed_limit > 0
    && motor_speed >= $unsigned(analog_speed_limit))[*6]
    |=> speed_limiting_out) else $error("limit reached, not flagged");
  c_strobe: cover property (data_strobe_in ##1 !data_strobe_in);
  c_cw: cover property (torque_dir == DIR_CW);
  c_limit: cover property (speed_limiting_out);
endmodule
bind speed_torque_command_select stcs_sva #(.W(W),
  .STROBE_CYCLES(STROBE_CYCLES), .STABLE_CYCLES(STABLE_CYCLES)) chk (.*);

// ===== sim/contact_ctl.sv
// controller model on the data contacts and strobe
`timescale 1ns/1ps
module contact_ctl (
  // clock
  input wire logic clk,
  // contacts, one when closed
  output logic [19:0] data_in,
  output logic data_strobe_in
);
  initial data_in = 20'h00000;
  initial data_strobe_in = 1'b0;
  // data leads the strobe and stays put until after it falls
  task automatic send(logic [19:0] d, int n, logic s);
    @(negedge clk);
    data_in = d;
    repeat (2) @(negedge clk);
    data_strobe_in = s;
    repeat (n) @(negedge clk);
    data_strobe_in = 1'b0;
    repeat (4) @(negedge clk);
  endtask
endmodule

// ===== sim/testbench.sv
// self-checking bench for the command selection block
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
  $display("ERROR %0t got %h", $time, a); end end
module testbench;
  import stcs_pkg::*;
  localparam int SC = 20;
  logic clk = 0, sys_rst = 1, clk_en = 1, torque_mode = 0, bcd_mode = 0;
  logic auto_read = 0, sel3_enable = 0, tbl_wr = 0, source_select_in = 0;
  logic speed_sel1_in = 0, speed_sel2_in = 0, speed_sel3_in = 0;
  logic reverse_select_in = 0, forward_select_in = 0;
  logic [15:0] full_scale_speed = 16'h1FFE, max_speed = 16'h7530;
  logic [15:0] torque_gain = 16'h1F40, motor_speed = 16'h0000;
  logic [15:0] tbl_data = 16'h0000, speed_cmd;
  logic signed [15:0] torque_offset_mv = 16'sh0000, torque_cmd;
  logic signed [15:0] analog_speed_cmd = 16'sh0123;
  logic signed [15:0] analog_speed_limit = 16'sh0200;
  logic signed [15:0] analog_torque_cmd = 16'sh03E8;
  logic [2:0] tbl_addr = 3'h0;
  logic [19:0] data_in;
  logic data_strobe_in, speed_reached_out, speed_limiting_out;
  dir_t torque_dir, limit_dir;
  dir_t dexp [6] = '{DIR_CW, DIR_CCW, DIR_CCW, DIR_CW, DIR_NONE, DIR_NONE};
  int failures = 0, n_tests = 0;
  speed_torque_command_select #(.W(16), .STROBE_CYCLES(SC),
    .STABLE_CYCLES(SC)) dut (.*);
  contact_ctl ctl (.*);
  task automatic wt(int n = 8);
    repeat (n) @(negedge clk);
  endtask
  task automatic test_done();
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial forever #20 clk = ~clk;
  initial begin
    wt(5000);
    failures++;
    test_done();
  end
  initial begin
    wt(20);
    sys_rst = 0;
    for (int i = 1; i < 8; i++) begin
      wt(1);
      {tbl_wr, tbl_addr, tbl_data} = {1'b1, 3'(i), 16'(i * 256)};
    end
    wt(1);
    tbl_wr = 0;
    `CHK(torque_cmd, 16'sh0000)
    ctl.send(20'hFF800, SC + 4, 1);
    wt();
    `CHK(speed_cmd, 16'h1000)
    ctl.send(20'h00FFF, SC - 4, 1);
    wt();
    `CHK(speed_cmd, 16'h1000)
    ctl.send(20'h00FFF, SC + 4, 1);
    {speed_sel3_in, speed_sel2_in, speed_sel1_in} = 3'h7;
    wt();
    `CHK(speed_cmd, 16'h1FFE)
    sel3_enable = 1;
    source_select_in = 1;
    for (int c = 0; c < 8; c++) begin
      {speed_sel3_in, speed_sel2_in, speed_sel1_in} = 3'(c);
      wt();
      `CHK(speed_cmd, c == 0 ? 16'h0123 : 16'(c * 256))
    end
    sel3_enable = 0;
    wt();
    `CHK(speed_cmd, 16'h0300)
    {speed_sel3_in, speed_sel2_in, speed_sel1_in} = 3'h0;
    motor_speed = 16'h0125;
    wt();
    `CHK(speed_reached_out, 1'b1)
    bcd_mode = 1;
    ctl.send(20'h12345, SC + 4, 1);
    wt();
    `CHK(speed_cmd, 16'h3039)
    ctl.send(20'h99999, SC + 4, 1);
    wt();
    `CHK(speed_cmd, 16'h7530)
    {bcd_mode, source_select_in, auto_read} = 3'h1;
    ctl.send(20'h00400, SC + 8, 0);
    `CHK(speed_cmd, 16'h0800)
    ctl.send(20'h00200, SC - 10, 0);
    `CHK(speed_cmd, 16'h0800)
    {auto_read, torque_mode} = 2'h1;
    for (int k = 0; k < 6; k++) begin
      forward_select_in = k inside {2, 3, 4};
      reverse_select_in = k inside {0, 1, 4};
      analog_torque_cmd = k[0] ? -16'sh03E8 : 16'sh03E8;
      wt();
      `CHK(torque_dir, dexp[k])
    end
    {forward_select_in, reverse_select_in} = 2'h2;
    torque_gain = 16'h1000;
    analog_torque_cmd = 16'sh1F40;
    wt();
    `CHK(torque_cmd, 16'sh1000)
    analog_torque_cmd = 16'sh03E8;
    torque_offset_mv = 16'sh01F4;
    motor_speed = 16'h0100;
    wt();
    `CHK(torque_cmd, 16'sh0300)
    `CHK(limit_dir, DIR_CCW)
    `CHK(speed_limiting_out, 1'b0)
    motor_speed = 16'h0300;
    wt();
    `CHK(speed_limiting_out, 1'b1)
    {speed_sel1_in, forward_select_in, reverse_select_in} = 3'h5;
    motor_speed = 16'h0100;
    wt();
    `CHK(speed_limiting_out, 1'b1)
    `CHK(limit_dir, DIR_CW)
    // clock enable low must freeze the flag despite the speed drop
    clk_en = 0;
    motor_speed = 16'h0000;
    wt();
    `CHK(speed_limiting_out, 1'b1)
    test_done();
  end
endmodule
